// ==== logic/sarseq_pkg.sv ====
package sarseq_pkg;
  // =====================================================================
  // register addresses
  localparam logic [15:0] MODE_ADDR      = 16'hFF80;
  localparam logic [15:0] RESULT_ADDR    = 16'hFF81;
  localparam logic [15:0] PIN_SEL_ADDR   = 16'hFF82;
  localparam logic [15:0] EDGE_SEL_ADDR  = 16'hFF83;
  localparam logic [15:0] REF_CUT_ADDR   = 16'hFF84;
  // =====================================================================
  // reset values
  localparam logic [7:0]  MODE_RESET     = 8'h01;
  localparam logic [7:0]  PIN_SEL_RESET  = 8'h00;
  localparam logic [7:0]  EDGE_SEL_RESET = 8'h00;
  localparam logic [7:0]  REF_CUT_RESET  = 8'h00;
  // =====================================================================
  // mode register fields
  localparam int MODE_RUN_BIT  = 7;
  localparam int MODE_TRIG_BIT = 6;
  localparam int MODE_HI_BIT   = 5;
  localparam int MODE_LO_BIT   = 4;
  localparam int MODE_CH_MSB   = 3;
  localparam int MODE_CH_LSB   = 1;
  localparam int MODE_AUX_BIT  = 0;
  // edge select: bits 1:0 hold the trigger input edge (00 fall, 01 rise, 1x both)
  localparam int EDGE_TRIG_MSB = 1;
  localparam int EDGE_TRIG_LSB = 0;
  // =====================================================================
  // conversion times in main clock periods
  localparam logic [2:0]  TIME_CODE_80   = 3'h1;
  localparam logic [2:0]  TIME_CODE_100  = 3'h5;
  localparam logic [7:0]  CONV_CYC_80    = 8'h50;
  localparam logic [7:0]  CONV_CYC_100   = 8'h64;
  localparam logic [7:0]  STEP_CYC_80    = 8'h08;
  localparam logic [7:0]  STEP_CYC_100   = 8'h0A;
  // sampling takes the remainder: total minus eight steps
  localparam logic [7:0]  SAMP_CYC_80    = CONV_CYC_80 - 8'h08 * STEP_CYC_80;
  localparam logic [7:0]  SAMP_CYC_100   = CONV_CYC_100 - 8'h08 * STEP_CYC_100;
  typedef enum logic [1:0]
  {
    SARSEQ_IDLE   = 2'b00,
    SARSEQ_ARMED  = 2'b01,
    SARSEQ_SAMPLE = 2'b10,
    SARSEQ_TRIAL  = 2'b11
  } sarseq_state_t;
endpackage

// ==== logic/sarseq_top.sv ====
// =====================================================================
// successive approximation converter sequencer
// Overview of operation
// - build result msb first, then move out
// - result register reloaded each conversion, read-only
// - mode register at FF80, reset 01
// - channel bits 3..1 select input 0..7
// - only 80 or 100 cycle codes allowed
// - trigger bit picks software or external start
// - run bit stops or enables conversion
// - pin select register, analog or port, reset 00
// - analog pins lose their pull-up
// - edge select register, byte write, reset 00
// - reference cut register, byte write, reset 00
// - sample fixed period, then hold to end
// - first trial sets bit 7, half tap
// - later trials keep bit if input above tap
// - latch result and raise done request together
// - mode bit-writable, others byte-only
// - software start repeats back to back
// - hardware start converts once per edge
// - rewrite with run in hardware mode rearms
// - write clearing run stops at once
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              clk_en_in,
  input  wire logic [15:0]       cpu_addr_in,
  input  wire logic              cpu_wr_in,
  input  wire logic              cpu_bit_wr_in,
  input  wire logic [2:0]        cpu_bit_idx_in,
  input  wire logic [DATA_W-1:0] cpu_wdata_in,
  output logic      [DATA_W-1:0] cpu_rdata_out,
  input  wire logic              external_trigger_input_in,
  input  wire logic              comparator_in,
  input  wire logic [7:0]        port_pullup_en_in,
  output logic      [DATA_W-1:0] ladder_tap_out,
  output logic      [2:0]        channel_sel_out,
  output logic                   sample_out,
  output logic                   conversion_done_irq_out,
  output logic      [7:0]        pin_analog_out,
  output logic      [7:0]        pullup_en_out,
  output logic                   reference_connect_out,
  output logic      [DATA_W-1:0] ext_edge_select_out,
  output logic                   busy_out
);

  // =====================================================================
  // register file
  logic [DATA_W-1:0] conversion_mode_reg_q;
  logic [DATA_W-1:0] pin_analog_select_reg_q;
  logic [DATA_W-1:0] ext_edge_select_reg_q;
  logic [DATA_W-1:0] reference_cut_reg_q;
  logic [DATA_W-1:0] conversion_result_reg_q;
  logic [DATA_W-1:0] approximation_reg_q;
  logic [DATA_W-1:0] approximation_reg_d;
  sarseq_state_t     state_q;
  sarseq_state_t     state_d;
  logic [7:0]        cyc_cnt_q;
  logic [7:0]        cyc_cnt_d;
  logic [2:0]        bit_idx_q;
  logic [2:0]        bit_idx_d;
  logic              done_q;
  logic              trig_meta_q;
  logic              trig_sync_q;
  logic              trig_prev_q;

  wire sel_mode   = (cpu_addr_in == MODE_ADDR);
  wire sel_result = (cpu_addr_in == RESULT_ADDR);
  wire sel_pin    = (cpu_addr_in == PIN_SEL_ADDR);
  wire sel_edge   = (cpu_addr_in == EDGE_SEL_ADDR);
  wire sel_ref    = (cpu_addr_in == REF_CUT_ADDR);
  // bit writes only reach the mode register
  wire mode_byte_wr = clk_en_in && cpu_wr_in && sel_mode;
  wire mode_bit_wr  = clk_en_in && cpu_bit_wr_in && sel_mode;
  wire mode_wr      = mode_byte_wr || mode_bit_wr;
  wire byte_wr      = clk_en_in && cpu_wr_in;

  logic [DATA_W-1:0] bit_mask;
  assign bit_mask = DATA_W'(1) << cpu_bit_idx_in;

  wire [DATA_W-1:0] mode_new = mode_byte_wr ? cpu_wdata_in
                             : (conversion_mode_reg_q & ~bit_mask) | (cpu_wdata_in[0] ? bit_mask : '0);

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      conversion_mode_reg_q   <= MODE_RESET;
      pin_analog_select_reg_q <= PIN_SEL_RESET;
      ext_edge_select_reg_q   <= EDGE_SEL_RESET;
      reference_cut_reg_q     <= REF_CUT_RESET;
    end
    else
    begin
      if (mode_wr)
        conversion_mode_reg_q <= mode_new;
      if (byte_wr && sel_pin)
        pin_analog_select_reg_q <= cpu_wdata_in;
      if (byte_wr && sel_edge)
        ext_edge_select_reg_q <= cpu_wdata_in;
      if (byte_wr && sel_ref)
        reference_cut_reg_q <= cpu_wdata_in;
    end
  end

  // result register is read-only: no write path
  assign cpu_rdata_out = sel_mode   ? conversion_mode_reg_q
                       : sel_result ? conversion_result_reg_q
                       : sel_pin    ? pin_analog_select_reg_q
                       : sel_edge   ? ext_edge_select_reg_q
                       : sel_ref    ? reference_cut_reg_q
                       : '0;

  // =====================================================================
  // mode decode
  wire       run_en   = conversion_mode_reg_q[MODE_RUN_BIT];
  wire       hw_start = conversion_mode_reg_q[MODE_TRIG_BIT];
  wire [2:0] time_code = {conversion_mode_reg_q[MODE_HI_BIT], conversion_mode_reg_q[MODE_LO_BIT],
                          conversion_mode_reg_q[MODE_AUX_BIT]};
  // prohibited codes fall back to the longest time rather than run fast
  wire       fast_time = (time_code == TIME_CODE_80);
  wire [7:0] samp_cyc  = fast_time ? SAMP_CYC_80 : SAMP_CYC_100;
  wire [7:0] step_cyc  = fast_time ? STEP_CYC_80 : STEP_CYC_100;
  wire [2:0] mode_chan = conversion_mode_reg_q[MODE_CH_MSB:MODE_CH_LSB];

  // the new value after a write decides run/trigger on the next cycle
  wire       new_run  = mode_new[MODE_RUN_BIT];
  wire       new_hw   = mode_new[MODE_TRIG_BIT];
  // a write that changes the time code must size its own sampling interval
  wire [2:0] new_time_code = {mode_new[MODE_HI_BIT], mode_new[MODE_LO_BIT], mode_new[MODE_AUX_BIT]};
  wire [7:0] new_samp_cyc  = (new_time_code == TIME_CODE_80) ? SAMP_CYC_80 : SAMP_CYC_100;

  // =====================================================================
  // trigger edge detect after a two-stage synchroniser
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      trig_meta_q <= external_trigger_input_in;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  wire [1:0] edge_mode = ext_edge_select_reg_q[EDGE_TRIG_MSB:EDGE_TRIG_LSB];
  wire rise = trig_sync_q && !trig_prev_q;
  wire fall = !trig_sync_q && trig_prev_q;
  wire trig_edge = edge_mode[1] ? (rise || fall)
                 : edge_mode[0] ? rise : fall;

  // =====================================================================
  // sequencer
  wire step_done = (cyc_cnt_q == 8'h01);
  wire last_bit  = (bit_idx_q == 3'h0);
  wire finish    = (state_q == SARSEQ_TRIAL) && step_done && last_bit;
  wire [DATA_W-1:0] decided = approximation_reg_q;

  always_comb
  begin
    state_d             = state_q;
    cyc_cnt_d           = cyc_cnt_q;
    bit_idx_d           = bit_idx_q;
    approximation_reg_d = approximation_reg_q;
    case (state_q)
      SARSEQ_IDLE:
      begin
        if (run_en)
          state_d = hw_start ? SARSEQ_ARMED : SARSEQ_SAMPLE;
        cyc_cnt_d = samp_cyc;
      end
      SARSEQ_ARMED:
      begin
        cyc_cnt_d = samp_cyc;
        if (trig_edge)
          state_d = SARSEQ_SAMPLE;
      end
      SARSEQ_SAMPLE:
      begin
        cyc_cnt_d = cyc_cnt_q - 8'h01;
        if (step_done)
        begin
          state_d             = SARSEQ_TRIAL;
          cyc_cnt_d           = step_cyc;
          bit_idx_d           = 3'h7;
          approximation_reg_d = {1'b1, {(DATA_W-1){1'b0}}};
        end
      end
      SARSEQ_TRIAL:
      begin
        cyc_cnt_d = cyc_cnt_q - 8'h01;
        if (step_done)
        begin
          // keep or drop the trial bit, then set the next one
          approximation_reg_d[bit_idx_q] = comparator_in;
          cyc_cnt_d = step_cyc;
          if (last_bit)
          begin
            // software mode runs back to back; hardware waits for the next edge
            state_d   = hw_start ? SARSEQ_ARMED : SARSEQ_SAMPLE;
            cyc_cnt_d = samp_cyc;
          end
          else
          begin
            bit_idx_d                      = bit_idx_q - 3'h1;
            approximation_reg_d[bit_idx_d] = 1'b1;
          end
        end
      end
      default:
        state_d = SARSEQ_IDLE;
    endcase
    if (!run_en)
      state_d = SARSEQ_IDLE;
    if (mode_wr)
    begin
      cyc_cnt_d = new_samp_cyc;
      if (!new_run)
        state_d = SARSEQ_IDLE;
      else
        state_d = new_hw ? SARSEQ_ARMED : SARSEQ_SAMPLE;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q             <= SARSEQ_IDLE;
      cyc_cnt_q           <= 8'h00;
      bit_idx_q           <= 3'h7;
      approximation_reg_q <= '0;
      done_q              <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_q             <= state_d;
      cyc_cnt_q           <= cyc_cnt_d;
      bit_idx_q           <= bit_idx_d;
      approximation_reg_q <= approximation_reg_d;
      done_q              <= finish && !mode_wr;
    end
  end

  // undefined after reset: no reset branch, loaded only at the end of a conversion
  always_ff @(posedge core_clk_in)
  begin
    if (clk_en_in && finish && !mode_wr)
      conversion_result_reg_q <= {approximation_reg_q[DATA_W-1:1], comparator_in};
  end

  // =====================================================================
  // analog side outputs
  assign ladder_tap_out          = decided;
  assign channel_sel_out         = mode_chan;
  assign sample_out              = (state_q == SARSEQ_SAMPLE);
  assign conversion_done_irq_out = done_q;
  assign busy_out                = (state_q == SARSEQ_SAMPLE) || (state_q == SARSEQ_TRIAL);
  assign pin_analog_out          = pin_analog_select_reg_q[7:0];
  assign pullup_en_out           = port_pullup_en_in & ~pin_analog_select_reg_q[7:0];
  assign reference_connect_out   = ~reference_cut_reg_q[0];
  assign ext_edge_select_out     = ext_edge_select_reg_q;

  // =====================================================================
  // assertions
  property p_done_result;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      conversion_done_irq_out |-> conversion_result_reg_q == approximation_reg_q;
  endproperty
  a_done_result: assert property (p_done_result) else $error("done without result load");

  property p_done_pulse;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      conversion_done_irq_out && clk_en_in |=> !conversion_done_irq_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done request longer than one cycle");

  property p_stop;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      mode_wr && !new_run |=> !busy_out && !conversion_done_irq_out;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion did not stop");

  property p_rearm;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      mode_wr && new_run && new_hw |=> state_q == SARSEQ_ARMED;
  endproperty
  a_rearm: assert property (p_rearm) else $error("hardware rewrite did not rearm");

  property p_first_trial;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && state_q == SARSEQ_SAMPLE && step_done && !mode_wr && run_en
        |=> ladder_tap_out == 8'h80;
  endproperty
  a_first_trial: assert property (p_first_trial) else $error("first trial tap not half");

  property p_pullup;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (pullup_en_out & pin_analog_out) == 8'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on analog pin");

  property p_run_off;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      !run_en && !mode_wr && clk_en_in |=> !busy_out;
  endproperty
  a_run_off: assert property (p_run_off) else $error("busy with run bit clear");

  property p_sample_len;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      $rose(sample_out) && fast_time |-> cyc_cnt_q == SAMP_CYC_80;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample interval wrong");

  property p_back_to_back;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && finish && !mode_wr && run_en && !hw_start |=> sample_out && conversion_done_irq_out;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("software mode did not restart");

  property p_one_shot;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      clk_en_in && finish && !mode_wr && run_en && hw_start |=> state_q == SARSEQ_ARMED && !busy_out;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("hardware mode did not wait");

  c_done:    cover property (@(posedge core_clk_in) conversion_done_irq_out);
  c_hw_wait: cover property (@(posedge core_clk_in) state_q == SARSEQ_ARMED ##1 state_q == SARSEQ_SAMPLE);
  c_abort:   cover property (@(posedge core_clk_in) busy_out && mode_wr && !new_run);
  c_repeat:  cover property (@(posedge core_clk_in) conversion_done_irq_out && sample_out);

endmodule

// ==== bench/sarseq_analog_model.sv ====
// =====================================
// comparator with sample and hold
module sarseq_analog_model
(
  input  wire logic        core_clk_in,
  input  wire logic [63:0] vin_in,
  input  wire logic [2:0]  channel_sel_in,
  input  wire logic        sample_in,
  input  wire logic        busy_in,
  input  wire logic [7:0]  ladder_tap_in,
  output logic             comparator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held_q;
  logic       tog_q = 1'b0;
  always_ff @(posedge core_clk_in)
  begin
    tog_q <= ~tog_q;
    if (sample_in)
      held_q <= vin_in[channel_sel_in*8 +: 8];
  end
  // no trial in progress: output flips so stale results cannot pass
  assign comparator_out = (busy_in && !sample_in) ? (held_q >= ladder_tap_in) : tog_q;
endmodule

// ==== bench/tb.sv ====
module tb
  import sarseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================
  // signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        bwr = 1'b0;
  logic        trig = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [2:0]  bidx = 3'h0;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  pu = 8'h00;
  logic [63:0] vin = 64'h0;
  logic [7:0]  rd, tap, pin_an, pu_o, edge_o;
  logic [2:0]  ch_o;
  logic        samp, irq, cmp, refc, busy;
  int          bad_count = 0;
  int          n_tests = 0;
  int          seed = 32'h5A1C;
  int          n, ns, nb, ni, ch, r;
  int          exp_q[$];
  always #2.5 clk = ~clk;
  sarseq_top uut
  (
    .core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(ce),
    .cpu_addr_in(addr), .cpu_wr_in(wr), .cpu_bit_wr_in(bwr),
    .cpu_bit_idx_in(bidx), .cpu_wdata_in(wd), .cpu_rdata_out(rd),
    .external_trigger_input_in(trig), .comparator_in(cmp),
    .port_pullup_en_in(pu), .ladder_tap_out(tap), .channel_sel_out(ch_o),
    .sample_out(samp), .conversion_done_irq_out(irq), .pin_analog_out(pin_an),
    .pullup_en_out(pu_o), .reference_connect_out(refc),
    .ext_edge_select_out(edge_o), .busy_out(busy)
  );
  sarseq_analog_model model
  (
    .core_clk_in(clk), .vin_in(vin), .channel_sel_in(ch_o), .sample_in(samp),
    .busy_in(busy), .ladder_tap_in(tap), .comparator_out(cmp)
  );
  // =====================================
  // tasks
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task wr_t(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task bwr_t(input logic [15:0] a, input logic [2:0] i, input logic v);
    @(negedge clk);
    addr = a;
    bidx = i;
    wd = {7'h00, v};
    bwr = 1'b1;
    @(negedge clk);
    bwr = 1'b0;
  endtask
  task rdchk(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    #1 chk(rd, e);
  endtask
  // input changes after the hold point, so only held values may show up
  task wt;
    n = 0;
    ns = 0;
    // the first sampling cycle already stands when the write task returns
    do
    begin
      ns += (samp === 1'b1);
      @(negedge clk);
      n++;
      if (n == 40)
      begin
        vin = {$random(seed), $random(seed)};
        exp_q.push_back(vin[ch*8 +: 8]);
      end
    end
    while (irq !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      bad_count++;
      stop_test;
    end
  endtask
  task idle(input int k);
    nb = 0;
    ni = 0;
    repeat (k)
    begin
      @(negedge clk);
      nb += (busy !== 1'b0);
      ni += (irq !== 1'b0);
    end
  endtask
  task conv(input logic [7:0] m);
    exp_q.delete();
    ch = m[3:1];
    exp_q.push_back(vin[ch*8 +: 8]);
    wr_t(MODE_ADDR, m);
    addr = RESULT_ADDR;
    wt;
  endtask
  // =====================================
  // main sequence
  initial
  begin
    pu = $random(seed);
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rdchk(MODE_ADDR, 8'h01);
    rdchk(PIN_SEL_ADDR, 8'h00);
    rdchk(EDGE_SEL_ADDR, 8'h00);
    rdchk(REF_CUT_ADDR, 8'h00);
    rdchk(16'hFF90, 8'h00);
    chk(refc, 1'b1);
    tend("reset");
    r = $random(seed);
    wr_t(PIN_SEL_ADDR, r[7:0]);
    rdchk(PIN_SEL_ADDR, r[7:0]);
    chk(pin_an, r[7:0]);
    chk(pu_o, pu & ~r[7:0]);
    bwr_t(PIN_SEL_ADDR, 3'h0, ~r[0]);
    rdchk(PIN_SEL_ADDR, r[7:0]);
    wr_t(EDGE_SEL_ADDR, r[15:8]);
    rdchk(EDGE_SEL_ADDR, r[15:8]);
    chk(edge_o, r[15:8]);
    wr_t(REF_CUT_ADDR, 8'h01);
    chk(refc, 1'b0);
    wr_t(REF_CUT_ADDR, 8'h00);
    wr_t(PIN_SEL_ADDR, 8'hFF);
    chk(pu_o, 8'h00);
    tend("registers");
    for (int i = 0; i < 8; i++)
    begin
      vin = {$random(seed), $random(seed)};
      conv({2'b10, i[0], 1'b0, i[2:0], 1'b1});
      chk(n, i[0] ? CONV_CYC_100 : CONV_CYC_80);
      chk(ns, i[0] ? SAMP_CYC_100 : SAMP_CYC_80);
      chk(rd, exp_q.pop_front());
      chk(ch_o, i);
      wt;
      r = exp_q.pop_front();
      chk(rd, r[7:0]);
    end
    tend("software");
    wr_t(MODE_ADDR, 8'h83);
    idle(30);
    wr_t(MODE_ADDR, 8'h03);
    chk(busy, 1'b0);
    // clock stop only after run is cleared; writes must not land while frozen
    ce = 1'b0;
    wr_t(PIN_SEL_ADDR, 8'h00);
    rdchk(PIN_SEL_ADDR, 8'hFF);
    ce = 1'b1;
    idle(200);
    chk(nb + ni, 0);
    wr_t(RESULT_ADDR, ~r[7:0]);
    rdchk(RESULT_ADDR, r[7:0]);
    chk(irq, 1'b0);
    bwr_t(MODE_ADDR, 3'h7, 1'b1);
    rdchk(MODE_ADDR, 8'h83);
    chk(busy, 1'b1);
    bwr_t(MODE_ADDR, 3'h7, 1'b0);
    rdchk(MODE_ADDR, 8'h03);
    tend("stop");
    wr_t(EDGE_SEL_ADDR, 8'h01);
    wr_t(MODE_ADDR, 8'hC3);
    idle(50);
    chk(nb, 0);
    for (int k = 0; k < 2; k++)
    begin
      exp_q.delete();
      exp_q.push_back(vin[15:8]);
      ch = 1;
      trig = 1'b1;
      addr = RESULT_ADDR;
      wt;
      chk(n >= 82 && n <= 86, 1'b1);
      chk(ns, 16);
      chk(rd, exp_q.pop_front());
      idle(200);
      chk(nb + ni, 0);
      trig = 1'b0;
      idle(50);
      chk(nb, 0);
      trig = 1'b1;
      idle(30);
      wr_t(MODE_ADDR, 8'hC3);
      idle(50);
      chk(nb + ni, 0);
      trig = 1'b0;
      idle(5);
    end
    tend("hardware");
    wr_t(MODE_ADDR, 8'h83);
    idle(20);
    rst_n = 1'b0;
    idle(6);
    chk(nb + ni, 0);
    rst_n = 1'b1;
    rdchk(MODE_ADDR, 8'h01);
    rdchk(EDGE_SEL_ADDR, 8'h00);
    chk(busy, 1'b0);
    tend("reset again");
    stop_test;
  end
endmodule
